// >>> core/trig_seq_pkg.sv
// package: constants and types for the trigger state sequencer
package trig_seq_pkg;
  localparam int TRIG_W = 4;
  localparam int CMD_ENTRIES = 16;
  localparam int STATE_W = 6;
  localparam int POS_W = 32;
  // filter time in nanoseconds, converted to clock cycles (round up)
  localparam int FILTER_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W = 16;
  localparam logic [STATE_W-1:0] STATE_RESET = 6'h00;

  // table command per input combination
  typedef enum logic [2:0] {
    TCMD_NOP,
    TCMD_NEXT,
    TCMD_PREV,
    TCMD_REPEAT,
    TCMD_GOTO
  } table_cmd_t;

  // movement kind programmed for a state
  typedef enum logic [2:0] {
    MV_NOP,
    MV_ABS,
    MV_REL,
    MV_CURVE,
    MV_STOP,
    MV_FREEZE
  } move_kind_t;

  // command entry field layout: [8:6] command, [5:0] goto state
  localparam int ENT_CMD_LSB = 6;
  localparam int ENT_W = 9;
endpackage

// >>> core/trig_filter_if.sv
// interface: filtered trigger combination and change event
`timescale 1ns/10ps
interface trig_filter_if;
  logic [trig_seq_pkg::TRIG_W-1:0] combo;
  logic changed;
  modport producer (output combo, output changed);
  modport consumer (input combo, input changed);
endinterface

// >>> core/trig_filter.sv
// module: jitter filter on the four trigger inputs
`timescale 1ns/10ps
module trig_filter #(
  parameter int FILTER_CYCLES = trig_seq_pkg::FILTER_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [trig_seq_pkg::TRIG_W-1:0] trig_in,
  trig_filter_if.producer out
);
  localparam int CW = trig_seq_pkg::FILT_CNT_W;
  logic [trig_seq_pkg::TRIG_W-1:0] last_reg;
  logic [trig_seq_pkg::TRIG_W-1:0] combo_reg;
  logic [CW-1:0] cnt_reg;
  logic init_reg;
  logic changed_reg;

  //////////////////////////////////////////////////////////////////////////
  // stability counter: a new value must stay put for the filter time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_reg <= '0;
      cnt_reg <= '0;
    end else if (trig_in != last_reg) begin
      last_reg <= trig_in;
      cnt_reg <= '0;
    end else if (cnt_reg != CW'(FILTER_CYCLES)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // accepted combination; first clock after reset takes the input [R18]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      combo_reg <= '0;
      init_reg <= 1'b1;
      changed_reg <= 1'b0;
    end else begin
      changed_reg <= 1'b0;
      if (init_reg) begin
        combo_reg <= trig_in; // [R18]
        init_reg <= 1'b0;
      end else if (trig_in == last_reg && cnt_reg == CW'(FILTER_CYCLES)
                   && last_reg != combo_reg) begin
        combo_reg <= last_reg; // [R10]
        changed_reg <= 1'b1; // only transitions raise an event [R17]
      end
    end
  end

  assign out.combo = combo_reg;
  assign out.changed = changed_reg;
endmodule

// >>> core/trigger_state_sequencer.sv
// module: multi-trigger state sequencer of a servo drive
`timescale 1ns/10ps
// Behaviour
// R1 - each of sixteen trigger combinations maps to one programmable command
// R2 - triggers act only in the running operating state
// R3 - no-operation keeps state index and starts no movement
// R4 - under no-operation a running movement finishes as programmed
// R5 - advance increments state index and runs its movement
// R6 - step-back decrements state index and runs its movement
// R7 - jump loads the programmed state number and runs its movement
// R8 - repeat reruns current state's movement, index unchanged
// R9 - master puts no-operation between repeats to make a change
// R10 - combination accepted only after stable for the filter time
// R11 - absolute or curve replaces running movement; no-op lets it continue
// R12 - relative adds to interrupted target, or to curve's last demand
// R13 - freeze ignores new movements; after stop relative uses stop position
// R14 - advancing into a no-op state starts nothing new
// R15 - stop state decelerates with that state's deceleration
// R16 - analog trigger mode disables all sequencing
// R17 - only a transition of the filtered combination evaluates the table
// R18 - reset: index zero, idle, filtered combination equals input
module trigger_state_sequencer #(
  parameter int FILTER_CYCLES = trig_seq_pkg::FILTER_CYC,
  parameter int NUM_STATES = 64
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // master control triggers
  input wire logic [trig_seq_pkg::TRIG_W-1:0] TRIG_IN,
  // drive mode
  input wire logic RUN_STATE,
  input wire logic ANALOG_COMMAND_MODE,
  // command table write port, one entry per combination
  input wire logic CMD_WE,
  input wire logic [trig_seq_pkg::TRIG_W-1:0] CMD_ADDR,
  input wire logic [trig_seq_pkg::ENT_W-1:0] CMD_DATA,
  // state table write port
  input wire logic ST_WE,
  input wire logic [trig_seq_pkg::STATE_W-1:0] ST_ADDR,
  input wire trig_seq_pkg::move_kind_t ST_KIND,
  input wire logic [trig_seq_pkg::POS_W-1:0] ST_VALUE,
  input wire logic [trig_seq_pkg::POS_W-1:0] ST_DECEL,
  // motion feedback
  input wire logic MOVE_DONE,
  input wire logic [trig_seq_pkg::POS_W-1:0] DEMAND_POS,
  input wire logic [trig_seq_pkg::POS_W-1:0] ACTUAL_POS,
  // motion request
  output logic MOVE_START,
  output trig_seq_pkg::move_kind_t MOVE_KIND,
  output logic [trig_seq_pkg::POS_W-1:0] MOVE_TARGET,
  output logic [trig_seq_pkg::POS_W-1:0] MOVE_DECEL,
  output logic MOVE_BUSY,
  output logic [trig_seq_pkg::STATE_W-1:0] STATE_INDEX
);
  localparam int SW = trig_seq_pkg::STATE_W;
  localparam int PW = trig_seq_pkg::POS_W;

  trig_filter_if filt ();

  //////////////////////////////////////////////////////////////////////////
  // jitter filter
  trig_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filter (
    .clk(MCLK),
    .rst(RST),
    .trig_in(TRIG_IN),
    .out(filt)
  );

  //////////////////////////////////////////////////////////////////////////
  // tables: loaded by configuration, held across reset
  logic [trig_seq_pkg::ENT_W-1:0] cmd_tab [trig_seq_pkg::CMD_ENTRIES];
  trig_seq_pkg::move_kind_t kind_tab [NUM_STATES];
  logic [PW-1:0] value_tab [NUM_STATES];
  logic [PW-1:0] decel_tab [NUM_STATES];

  // command table indexed by the combination [R1]
  always_ff @(posedge MCLK) begin
    if (CMD_WE) begin
      cmd_tab[CMD_ADDR] <= CMD_DATA; // [R1]
    end
  end

  always_ff @(posedge MCLK) begin
    if (ST_WE) begin
      kind_tab[ST_ADDR] <= ST_KIND;
      value_tab[ST_ADDR] <= ST_VALUE;
      decel_tab[ST_ADDR] <= ST_DECEL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command decode
  function automatic trig_seq_pkg::table_cmd_t entry_cmd(
    input logic [trig_seq_pkg::ENT_W-1:0] e);
    entry_cmd = trig_seq_pkg::table_cmd_t'(e[trig_seq_pkg::ENT_W-1:
                                             trig_seq_pkg::ENT_CMD_LSB]);
  endfunction

  logic [trig_seq_pkg::ENT_W-1:0] entry;
  trig_seq_pkg::table_cmd_t cmd;
  logic trigger_ok;
  logic [SW-1:0] index_reg;
  logic [SW-1:0] index_next;
  logic invoke;

  assign entry = cmd_tab[filt.combo];
  assign cmd = entry_cmd(entry);
  // analog mode or a non-running drive turns the sequencer off [R2] [R16]
  assign trigger_ok = filt.changed && RUN_STATE && !ANALOG_COMMAND_MODE;

  // next index per table command; a held value never gets here [R17]
  always_comb begin
    index_next = index_reg;
    invoke = 1'b0;
    case (cmd)
      trig_seq_pkg::TCMD_NOP: begin
        invoke = 1'b0; // index kept, nothing started [R3]
      end
      trig_seq_pkg::TCMD_NEXT: begin
        index_next = index_reg + 1'b1; // [R5]
        invoke = 1'b1;
      end
      trig_seq_pkg::TCMD_PREV: begin
        index_next = index_reg - 1'b1; // [R6]
        invoke = 1'b1;
      end
      trig_seq_pkg::TCMD_REPEAT: begin
        invoke = 1'b1; // same index, rerun; master inserts no-op [R8] [R9]
      end
      trig_seq_pkg::TCMD_GOTO: begin
        index_next = entry[SW-1:0]; // [R7]
        invoke = 1'b1;
      end
      default: begin
        invoke = 1'b0;
      end
    endcase
  end

  // state index
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      index_reg <= trig_seq_pkg::STATE_RESET; // [R18]
    end else if (trigger_ok) begin
      index_reg <= index_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // movement merge: one cycle after the index update the new state's
  // entry is read, so the table lookup never sits in the decode path
  logic pend_reg;
  trig_seq_pkg::move_kind_t run_kind_reg;
  logic busy_reg;
  trig_seq_pkg::move_kind_t new_kind;
  logic [PW-1:0] new_value;

  assign new_kind = kind_tab[index_reg];
  assign new_value = value_tab[index_reg];

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= trigger_ok && invoke;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      MOVE_START <= 1'b0;
      MOVE_KIND <= trig_seq_pkg::MV_NOP;
      MOVE_TARGET <= '0;
      MOVE_DECEL <= '0;
      run_kind_reg <= trig_seq_pkg::MV_NOP;
      busy_reg <= 1'b0; // [R18]
    end else begin
      MOVE_START <= 1'b0;
      if (busy_reg && MOVE_DONE && run_kind_reg != trig_seq_pkg::MV_FREEZE) begin
        busy_reg <= 1'b0; // running movement ends on its own [R4]
      end
      // while frozen every new movement is dropped [R13]
      if (pend_reg && !(busy_reg &&
                        run_kind_reg == trig_seq_pkg::MV_FREEZE)) begin
        case (new_kind)
          trig_seq_pkg::MV_NOP: begin
            // old movement continues, nothing new [R11] [R14]
          end
          trig_seq_pkg::MV_ABS, trig_seq_pkg::MV_CURVE: begin
            MOVE_START <= 1'b1; // replaces any running movement [R11]
            MOVE_KIND <= new_kind;
            MOVE_TARGET <= new_value;
            run_kind_reg <= new_kind;
            busy_reg <= 1'b1;
          end
          trig_seq_pkg::MV_REL: begin
            MOVE_START <= 1'b1;
            MOVE_KIND <= trig_seq_pkg::MV_ABS;
            // unfinished abs/rel adds to its target, curve to last demand;
            // idle or stopped uses the position where the slider is [R12]
            if (busy_reg && (run_kind_reg == trig_seq_pkg::MV_ABS ||
                             run_kind_reg == trig_seq_pkg::MV_REL)) begin
              MOVE_TARGET <= MOVE_TARGET + new_value; // [R12]
            end else if (busy_reg &&
                         run_kind_reg == trig_seq_pkg::MV_CURVE) begin
              MOVE_TARGET <= DEMAND_POS + new_value; // [R12]
            end else begin
              MOVE_TARGET <= ACTUAL_POS + new_value; // [R13]
            end
            run_kind_reg <= trig_seq_pkg::MV_REL;
            busy_reg <= 1'b1;
          end
          trig_seq_pkg::MV_STOP: begin
            MOVE_START <= 1'b1;
            MOVE_KIND <= trig_seq_pkg::MV_STOP;
            MOVE_DECEL <= decel_tab[index_reg]; // [R15]
            run_kind_reg <= trig_seq_pkg::MV_STOP;
            busy_reg <= 1'b1;
          end
          trig_seq_pkg::MV_FREEZE: begin
            MOVE_START <= 1'b1;
            MOVE_KIND <= trig_seq_pkg::MV_FREEZE;
            run_kind_reg <= trig_seq_pkg::MV_FREEZE;
            busy_reg <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // registered status outputs
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      MOVE_BUSY <= 1'b0;
      STATE_INDEX <= trig_seq_pkg::STATE_RESET;
    end else begin
      MOVE_BUSY <= busy_reg;
      STATE_INDEX <= index_reg;
    end
  end
endmodule

// >>> verification/trig_seq_monitor.sv
// checker: port timing of the trigger state sequencer
`timescale 1ns/10ps
module trig_seq_monitor #(
  parameter int FILTER_CYCLES = 3
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // watched inputs
  input wire logic [3:0] TRIG_IN,
  input wire logic RUN_STATE,
  input wire logic ANALOG_COMMAND_MODE,
  // watched outputs
  input wire logic MOVE_START,
  input wire trig_seq_pkg::move_kind_t MOVE_KIND,
  input wire logic [31:0] MOVE_TARGET,
  input wire logic [31:0] MOVE_DECEL,
  input wire logic MOVE_BUSY,
  input wire logic [5:0] STATE_INDEX
);
  logic [7:0] quiet_reg;
  logic frozen_reg;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////
  // cycles since the triggers last moved; saturates so it never wraps
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) quiet_reg <= 8'h00;
    else if ($changed(TRIG_IN)) quiet_reg <= 8'h00;
    else if (quiet_reg != 8'hFF) quiet_reg <= quiet_reg + 8'h01;
  end

  // a freeze, once started, lasts until reset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) frozen_reg <= 1'b0;
    else if (MOVE_START && MOVE_KIND == trig_seq_pkg::MV_FREEZE)
      frozen_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  a_start_single: assert property (MOVE_START |=> !MOVE_START [*3])
    else $error("start pulse repeated");
  a_out_hold: assert property (!MOVE_START |->
    $stable(MOVE_KIND) && $stable(MOVE_TARGET))
    else $error("movement changed without start");
  a_decel_hold: assert property (!MOVE_START |-> $stable(MOVE_DECEL))
    else $error("deceleration changed without start");
  a_mode_gate: assert property (MOVE_START |->
    $past(RUN_STATE, 2) && !$past(ANALOG_COMMAND_MODE, 2))
    else $error("start outside running mode");
  a_reset_idle: assert property ($fell(RST) |->
    STATE_INDEX == 6'h00 && !MOVE_BUSY && !MOVE_START)
    else $error("not idle after reset");
  a_index_quiet: assert property (quiet_reg > FILTER_CYCLES + 6 |->
    $stable(STATE_INDEX))
    else $error("index moved on steady triggers");
  a_start_quiet: assert property (quiet_reg > FILTER_CYCLES + 6 |->
    !MOVE_START)
    else $error("start on steady triggers");
  a_freeze_block: assert property (frozen_reg |-> !MOVE_START)
    else $error("start while frozen");
endmodule

bind trigger_state_sequencer trig_seq_monitor #(
  .FILTER_CYCLES(FILTER_CYCLES)
) i_trig_seq_monitor (
  .MCLK(MCLK), .RST(RST), .TRIG_IN(TRIG_IN), .RUN_STATE(RUN_STATE),
  .ANALOG_COMMAND_MODE(ANALOG_COMMAND_MODE), .MOVE_START(MOVE_START),
  .MOVE_KIND(MOVE_KIND), .MOVE_TARGET(MOVE_TARGET),
  .MOVE_DECEL(MOVE_DECEL), .MOVE_BUSY(MOVE_BUSY),
  .STATE_INDEX(STATE_INDEX)
);

// >>> verification/plc_model.sv
// partner: master control presenting trigger combinations
`timescale 1ns/10ps
module plc_model #(
  parameter int HOLD = 12
) (
  // clock
  input wire logic clk,
  // trigger lines
  output logic [3:0] trig
);
  initial trig = 4'h0;

  // present one combination; a short one is withdrawn as a glitch
  task automatic present(input logic [3:0] c, input bit short_hold);
    logic [3:0] prev;
    prev = trig;
    // same code twice needs a different one between
    if (c == trig && !short_hold) begin
      trig = 4'h0;
      repeat (HOLD) @(negedge clk);
    end
    trig = c;
    // a normal one is held well past the filter time, a short one two cycles
    repeat (short_hold ? 2 : HOLD) @(negedge clk);
    if (short_hold) trig = prev;
  endtask
endmodule

// >>> verification/tb_top.sv
// testbench: sequencer driven by the master control model
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic ana = 1'b0;
  logic cmd_we = 1'b0;
  logic [3:0] cmd_addr = 4'h0;
  logic [8:0] cmd_data = 9'h000;
  logic st_we = 1'b0;
  logic [5:0] st_addr = 6'h00;
  trig_seq_pkg::move_kind_t st_kind = trig_seq_pkg::MV_NOP;
  logic [31:0] st_val = 32'h0, st_dec = 32'h0, dpos = 32'h0, apos = 32'h0;
  logic done = 1'b0;
  logic [3:0] trig;
  logic start, busy;
  trig_seq_pkg::move_kind_t kind, k, last_k;
  logic [31:0] tgt, dec, last_t, base;
  logic [5:0] idx, e_idx;
  logic [3:0] cur_c;
  logic [8:0] ctab [16];
  trig_seq_pkg::move_kind_t sk [64];
  logic [31:0] sv [64], sd [64];
  int miscompares = 0, cmp_count = 0, starts = 0, cyc = 0;
  bit frz, mv;

  trigger_state_sequencer #(.FILTER_CYCLES(3)) i_trigger_state_sequencer (
    .MCLK(mclk), .RST(rst), .TRIG_IN(trig), .RUN_STATE(run),
    .ANALOG_COMMAND_MODE(ana), .CMD_WE(cmd_we), .CMD_ADDR(cmd_addr),
    .CMD_DATA(cmd_data), .ST_WE(st_we), .ST_ADDR(st_addr),
    .ST_KIND(st_kind), .ST_VALUE(st_val), .ST_DECEL(st_dec),
    .MOVE_DONE(done), .DEMAND_POS(dpos), .ACTUAL_POS(apos),
    .MOVE_START(start), .MOVE_KIND(kind), .MOVE_TARGET(tgt),
    .MOVE_DECEL(dec), .MOVE_BUSY(busy), .STATE_INDEX(idx));
  plc_model #(.HOLD(12)) i_plc_model (.clk(mclk), .trig(trig));

  ////////////////////////////////////////////////////////////////////////
  // clock, start counter and hang guard
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (start === 1'b1) starts++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [5:0] next_idx(logic [5:0] i, logic [8:0] e);
    case (e[8:6])
      3'h1: return i + 6'h01;
      3'h2: return i - 6'h01;
      3'h4: return e[5:0];
      default: return i;
    endcase
  endfunction

  task automatic wcmd(input logic [3:0] a, input logic [8:0] d);
    cmd_we = 1'b1;
    cmd_addr = a;
    cmd_data = d;
    ctab[a] = d;
    // strobe stays up between back-to-back writes; caller drops it
    @(negedge mclk);
  endtask

  task automatic wst(input logic [5:0] a, input int kd, input logic [31:0] v);
    st_we = 1'b1;
    st_addr = a;
    st_kind = trig_seq_pkg::move_kind_t'(kd);
    st_val = v;
    st_dec = ~v;
    sk[a] = st_kind;
    sv[a] = v;
    sd[a] = ~v;
    @(negedge mclk);
  endtask

  // one combination, then the expected index and movement
  task automatic send(input logic [3:0] c, input bit blip);
    int n;
    bit go;
    n = starts;
    go = !blip && run && !ana && (c != cur_c || c != 4'h0);
    i_plc_model.present(c, blip);
    repeat (12) @(negedge mclk);
    if (!blip) cur_c = c;
    if (go && ctab[c][8:6] != 3'h0) begin
      e_idx = next_idx(e_idx, ctab[c]);
      go = sk[e_idx] != trig_seq_pkg::MV_NOP && !frz;
    end else go = 0;
    check(idx, e_idx);
    check(starts - n, go);
    if (go) begin
      k = sk[e_idx];
      base = (mv && !done && last_k == trig_seq_pkg::MV_CURVE) ? dpos :
             (mv && !done && last_k == trig_seq_pkg::MV_ABS) ? last_t : apos;
      if (k == trig_seq_pkg::MV_REL) check(tgt, base + sv[e_idx]);
      else if (k == trig_seq_pkg::MV_STOP) check(dec, sd[e_idx]);
      else if (k != trig_seq_pkg::MV_FREEZE) check(tgt, sv[e_idx]);
      if (k == trig_seq_pkg::MV_REL) k = trig_seq_pkg::MV_ABS;
      check(kind, k);
      last_k = k;
      last_t = tgt;
      // a done level already high ends the new movement right away, except a freeze
      mv = !done;
      frz = k == trig_seq_pkg::MV_FREEZE;
    end
    check(busy, mv || frz);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence: tables, corner cases, random walk, freeze, reset
  initial begin
    void'($urandom(75467));
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    {cur_c, e_idx, frz, mv} = {trig, 6'h00, 2'b00};
    last_k = trig_seq_pkg::MV_NOP;
    // write strobes stay high across a whole table load
    for (int a = 0; a < 16; a++)
      wcmd(4'(a), a < 4 ? {3'(a), 6'h00} : {3'h4, 6'($urandom)});
    cmd_we = 1'b0;
    for (int s = 0; s < 64; s++) wst(6'(s), $urandom_range(4), $urandom);
    st_we = 1'b0;
    send(4'h4, 0);
    send(4'h1, 0);
    send(4'h0, 0);
    send(4'h3, 0);
    send(4'h3, 0);
    send(4'h2, 0);
    send(4'h1, 1);
    run = 1'b0;
    send(4'h1, 0);
    run = 1'b1;
    ana = 1'b1;
    send(4'h2, 0);
    ana = 1'b0;
    for (int i = 0; i < 40; i++) begin
      done = 1'($urandom);
      mv = mv && !done;
      {apos, dpos} = {$urandom, $urandom};
      send(4'($urandom), 0);
    end
    wst(6'h05, 5, 32'h0);
    st_we = 1'b0;
    wcmd(4'h4, {3'h4, 6'h05});
    cmd_we = 1'b0;
    send(4'h4, 0);
    send(4'h1, 0); // frozen: index moves, nothing starts
    rst = 1'b1;
    @(negedge mclk);
    check(start, 1'b0);
    rst = 1'b0;
    @(negedge mclk);
    check(idx, 6'h00);
    {cur_c, e_idx, frz, mv} = {trig, 6'h00, 2'b00};
    send(4'h1, 0);
    conclude();
  end
endmodule
